// >>> uvepc_consts.vh
`ifndef UVEPC_CONSTS_VH
`define UVEPC_CONSTS_VH
`define UVEPC_CLK_MHZ          40
`define UVEPC_GATE_DELAY_NS    120
`define UVEPC_ACCESS_NS        450
`define UVEPC_PULSE_US         50000
`define UVEPC_PULSE_MAX_US     55000
`define UVEPC_SETUP_NS         2000
`define UVEPC_GATE_CYC   ((`UVEPC_GATE_DELAY_NS*`UVEPC_CLK_MHZ+999)/1000)
`define UVEPC_ACCESS_CYC ((`UVEPC_ACCESS_NS*`UVEPC_CLK_MHZ+999)/1000)
`define UVEPC_PULSE_CYC  (`UVEPC_PULSE_US*`UVEPC_CLK_MHZ)
`define UVEPC_PULSE_MAX_CYC (`UVEPC_PULSE_MAX_US*`UVEPC_CLK_MHZ)
`define UVEPC_SETUP_CYC  ((`UVEPC_SETUP_NS*`UVEPC_CLK_MHZ+999)/1000)
`define UVEPC_ADDR_W     11
`define UVEPC_DATA_W     8
`define UVEPC_ERASED     8'hff
`endif

// >>> uvepc_timer.v
`timescale 1ns/1ps
`include "uvepc_consts.vh"
module uvepc_timer #(
   parameter CNT_W = 22
) (
   input  wire             core_clk_in,
   input  wire             rst_in,
   input  wire             load_in,
   input  wire [CNT_W-1:0] count_in,
   output reg              done_out
);
   reg [CNT_W-1:0] cnt_reg;
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_reg  <= {CNT_W{1'b0}};
         done_out <= 1'b0;
      end else if (load_in) begin
         cnt_reg  <= count_in;
         done_out <= 1'b0;
      end else if (cnt_reg != {CNT_W{1'b0}}) begin
         cnt_reg  <= cnt_reg - 1'b1;
         done_out <= (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
      end else begin
         done_out <= 1'b0;
      end
   end
endmodule

// >>> uvepc_host.v
`timescale 1ns/1ps
`include "uvepc_consts.vh"
// Overview of operation
// - Program mode is high supply with gate high; byte on data pins
// - One high strobe pulse, nominal 50 ms, never over 55 ms
// - One separate pulse for each location, any order
// - Strobe is never held statically high while programming
// - High supply, gate high, strobe low: no programming, outputs float
// - Verify: high supply, select low, gate low, device outputs byte
// - Programmer reads back and compares each programmed byte
// - Supply stays normal outside program and verify
// - Shared strobe pulse may program parallel devices with same data
// - Select decoded per device, gates common to the read strobe
module uvepc_host #(
   parameter PULSE_CYC = `UVEPC_PULSE_CYC,
   parameter DEV_N     = 1
) (
   input  wire                     core_clk_in,
   input  wire                     rst_in,
   input  wire                     rd_req_in,
   input  wire                     wr_req_in,
   input  wire [`UVEPC_ADDR_W-1:0] addr_in,
   input  wire [`UVEPC_DATA_W-1:0] wdata_in,
   input  wire [DEV_N-1:0]         dev_sel_in,
   input  wire [`UVEPC_DATA_W-1:0] mem_data_in,
   output reg                      busy_out,
   output reg                      done_out,
   output reg                      verify_err_out,
   output reg  [`UVEPC_DATA_W-1:0] rdata_out,
   output reg  [`UVEPC_ADDR_W-1:0] mem_addr_out,
   output reg  [`UVEPC_DATA_W-1:0] mem_data_out,
   output reg                      mem_data_oe_out,
   output reg  [DEV_N-1:0]         select_or_program_strobe_out,
   output reg                      output_gate_n_out,
   output reg                      prog_supply_high_out
);
   localparam S_IDLE   = 3'd0;
   localparam S_RSEL   = 3'd1;
   localparam S_RGATE  = 3'd2;
   localparam S_PSETUP = 3'd3;
   localparam S_PULSE  = 3'd4;
   localparam S_PHOLD  = 3'd5;
   localparam S_VGATE  = 3'd6;
   localparam S_DONE   = 3'd7;
   localparam CNT_W    = 22;
   localparam integer ACC_I  = `UVEPC_ACCESS_CYC;
   localparam integer GATE_I = `UVEPC_GATE_CYC;
   localparam integer SET_I  = `UVEPC_SETUP_CYC;
   localparam integer MAX_I  = `UVEPC_PULSE_MAX_CYC;
   // A width past the maximum is out of spec, so it is clipped; two cycles
   // is the least that the pulse timer can count
   localparam integer PLS_I  = (PULSE_CYC > MAX_I) ? MAX_I :
                               (PULSE_CYC < 2) ? 2 : PULSE_CYC;
   localparam [CNT_W-1:0] ACC_CYC  = ACC_I[CNT_W-1:0];
   localparam [CNT_W-1:0] GATE_CYC = GATE_I[CNT_W-1:0];
   localparam [CNT_W-1:0] SET_CYC  = SET_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PLS_CYC  = PLS_I[CNT_W-1:0];

   reg [2:0]               state_reg;
   reg [2:0]               state_next;
   reg [`UVEPC_DATA_W-1:0] sync1_reg;
   reg [`UVEPC_DATA_W-1:0] sync2_reg;
   reg [`UVEPC_DATA_W-1:0] wbyte_reg;
   reg                     load;
   reg [CNT_W-1:0]         load_val;
   wire                    tdone;
   reg [DEV_N-1:0]         sel_reg;
   reg [DEV_N-1:0]         vpend_reg;
   wire [DEV_N-1:0]        vpick;
   wire [DEV_N-1:0]        vseen;

   // Lowest pending device first; verifying one device at a time keeps
   // the shared data lines free of contention
   assign vseen[0] = 1'b0;
   genvar g;
   generate
      for (g = 0; g < DEV_N; g = g + 1) begin : g_pick
         assign vpick[g] = vpend_reg[g] & ~vseen[g];
         if (g + 1 < DEV_N) begin : g_next
            assign vseen[g+1] = vseen[g] | vpend_reg[g];
         end
      end
   endgenerate

   // Pin data passes two flops before compare or capture
   always @(posedge core_clk_in) begin
      sync1_reg <= mem_data_in;
      sync2_reg <= sync1_reg;
   end

   uvepc_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .core_clk_in(core_clk_in),
      .rst_in     (rst_in),
      .load_in    (load),
      .count_in   (load_val),
      .done_out   (tdone)
   );

   always @* begin
      state_next = state_reg;
      load       = 1'b0;
      load_val   = {CNT_W{1'b0}};
      case (state_reg)
         S_IDLE: begin
            if (wr_req_in) begin
               state_next = S_PSETUP;
               load       = 1'b1;
               load_val   = SET_CYC;
            end else if (rd_req_in) begin
               state_next = S_RSEL;
               // Select-to-data equals address access, minus gate delay
               load       = 1'b1;
               load_val   = ACC_CYC - GATE_CYC;
            end
         end
         S_RSEL: begin
            if (tdone) begin
               state_next = S_RGATE;
               load       = 1'b1;
               load_val   = GATE_CYC + 22'd2;
            end
         end
         S_RGATE: begin
            if (tdone)
               state_next = S_DONE;
         end
         S_PSETUP: begin
            if (tdone) begin
               state_next = S_PULSE;
               load       = 1'b1;
               // The state moves a cycle after done rises, so one less
               // leaves the strobe high for exactly PLS_CYC cycles
               load_val   = PLS_CYC - 22'd1;
            end
         end
         S_PULSE: begin
            if (tdone) begin
               state_next = S_PHOLD;
               load       = 1'b1;
               load_val   = SET_CYC;
            end
         end
         S_PHOLD: begin
            if (tdone) begin
               state_next = S_VGATE;
               load       = 1'b1;
               load_val   = ACC_CYC + 22'd2;
            end
         end
         S_VGATE: begin
            if (tdone) begin
               // Further devices of a parallel group are verified in turn
               if (|(vpend_reg & ~vpick)) begin
                  state_next = S_PHOLD;
                  load       = 1'b1;
                  load_val   = SET_CYC;
               end else begin
                  state_next = S_DONE;
               end
            end
         end
         S_DONE: begin
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg                    <= S_IDLE;
         busy_out                     <= 1'b0;
         done_out                     <= 1'b0;
         verify_err_out               <= 1'b0;
         rdata_out                    <= `UVEPC_ERASED;
         mem_addr_out                 <= {`UVEPC_ADDR_W{1'b0}};
         mem_data_out                 <= `UVEPC_ERASED;
         mem_data_oe_out              <= 1'b0;
         select_or_program_strobe_out <= {DEV_N{1'b1}};
         output_gate_n_out            <= 1'b1;
         prog_supply_high_out         <= 1'b0;
         wbyte_reg                    <= `UVEPC_ERASED;
         sel_reg                      <= {DEV_N{1'b0}};
         vpend_reg                    <= {DEV_N{1'b0}};
      end else begin
         state_reg <= state_next;
         done_out  <= 1'b0;
         if (state_reg == S_VGATE && tdone) begin
            verify_err_out <= verify_err_out | (sync2_reg != wbyte_reg);
            vpend_reg      <= vpend_reg & ~vpick;
         end
         case (state_next)
            S_IDLE: begin
               busy_out                     <= 1'b0;
               // Standby: every device deselected, outputs float
               select_or_program_strobe_out <= {DEV_N{1'b1}};
               output_gate_n_out            <= 1'b1;
               mem_data_oe_out              <= 1'b0;
               prog_supply_high_out         <= 1'b0;
            end
            S_RSEL: begin
               busy_out <= 1'b1;
               if (state_reg == S_IDLE) begin
                  mem_addr_out <= addr_in;
                  // Every device set in dev_sel_in is selected, not only one
                  select_or_program_strobe_out <= ~dev_sel_in;
               end
            end
            S_RGATE: begin
               output_gate_n_out <= 1'b0;
            end
            S_PSETUP: begin
               busy_out <= 1'b1;
               if (state_reg == S_IDLE) begin
                  mem_addr_out    <= addr_in;
                  mem_data_out    <= wdata_in;
                  wbyte_reg       <= wdata_in;
                  sel_reg         <= dev_sel_in;
                  vpend_reg       <= dev_sel_in;
                  mem_data_oe_out <= 1'b1;
                  verify_err_out  <= 1'b0;
                  // Strobe low, gate high, supply high: inhibit
                  select_or_program_strobe_out <= {DEV_N{1'b0}};
                  output_gate_n_out            <= 1'b1;
                  prog_supply_high_out         <= 1'b1;
               end
            end
            S_PULSE: begin
               // Pulse only the chosen devices; others stay inhibited
               select_or_program_strobe_out <= sel_reg;
            end
            S_PHOLD: begin
               // Strobe always returns low, never a static level
               select_or_program_strobe_out <= {DEV_N{1'b0}};
               output_gate_n_out            <= 1'b1;
            end
            S_VGATE: begin
               if (state_reg == S_PHOLD) begin
                  // Release the data pins before opening the gate
                  mem_data_oe_out <= 1'b0;
                  // Verify one device at a time; shared data would clash
                  select_or_program_strobe_out <= ~vpick;
               end else begin
                  output_gate_n_out <= 1'b0;
               end
            end
            S_DONE: begin
               done_out          <= 1'b1;
               rdata_out         <= sync2_reg;
               output_gate_n_out <= 1'b1;
               // Supply falls a cycle before the strobe rises to standby,
               // so that rise can never be taken for a program pulse
               prog_supply_high_out <= 1'b0;
            end
            default: begin
               busy_out <= 1'b0;
            end
         endcase
      end
   end
endmodule

// >>> uvepc_monitor.sv
`timescale 1ns/1ps
module uvepc_monitor #(
   parameter PULSE_CYC = 2000000,
   parameter DEV_N     = 1
) (
   input wire             core_clk_in,
   input wire             rst_in,
   input wire             rd_req_in,
   input wire             wr_req_in,
   input wire [10:0]      addr_in,
   input wire             busy_out,
   input wire             done_out,
   input wire [10:0]      mem_addr_out,
   input wire             mem_data_oe_out,
   input wire [DEV_N-1:0] select_or_program_strobe_out,
   input wire             output_gate_n_out,
   input wire             prog_supply_high_out
);
reg  [21:0] hi_cnt_reg;
wire        pul = select_or_program_strobe_out[0] & prog_supply_high_out;
// Counts the live pulse so its width is checked without long repeats
always @(posedge core_clk_in) begin
   if (rst_in || !pul)
      hi_cnt_reg <= 22'h000000;
   else
      hi_cnt_reg <= hi_cnt_reg + 22'h000001;
end
default clocking @(posedge core_clk_in); endclocking
default disable iff (rst_in);
sequence s_rd_take; !busy_out && rd_req_in && !wr_req_in; endsequence
sequence s_wr_take; !busy_out && wr_req_in; endsequence
chk_read_steps: assert property (s_rd_take |=> (busy_out && output_gate_n_out
   && !prog_supply_high_out)[*8] ##[1:40] done_out) else $error("read walk");
chk_prog_steps: assert property (s_wr_take |=> (prog_supply_high_out
   && !select_or_program_strobe_out[0] && mem_data_oe_out)[*8] ##[90:300] done_out)
   else $error("program walk");
chk_addr_taken: assert property (!busy_out && (rd_req_in || wr_req_in)
   |=> mem_addr_out == $past(addr_in)) else $error("address not taken");
chk_gate_needs_sel: assert property (!output_gate_n_out
   |-> !select_or_program_strobe_out[0] && !mem_data_oe_out) else $error("gate");
chk_drive_prog: assert property (mem_data_oe_out
   |-> prog_supply_high_out && output_gate_n_out) else $error("data drive");
chk_supply_idle: assert property (!busy_out && !$past(busy_out)
   |-> !prog_supply_high_out) else $error("supply high while idle");
chk_done_once: assert property (done_out |=> !done_out && !busy_out)
   else $error("done not single");
chk_pulse_max: assert property (hi_cnt_reg <= PULSE_CYC)
   else $error("pulse too long");
chk_pulse_len: assert property (hi_cnt_reg != 0 && !pul
   |-> hi_cnt_reg == PULSE_CYC) else $error("pulse width");
endmodule
bind uvepc_host uvepc_monitor #(.PULSE_CYC(PULSE_CYC), .DEV_N(DEV_N)) mon (.*);

// >>> uvepc_dev_model.sv
`timescale 1ns/1ps
module uvepc_dev_model (
   input  wire        strobe_in,
   input  wire        gate_n_in,
   input  wire        vpp_in,
   input  wire [10:0] addr_in,
   input  wire [7:0]  din_in,
   output wire [7:0]  dout_out,
   output wire        drive_out
);
reg [7:0] mem [0:2047];
reg       armed;
integer   i;
initial begin
   armed = 1'b0;
   for (i = 0; i < 2048; i = i + 1)
      mem[i] = 8'hff;
end
assign #120 drive_out = !strobe_in && !gate_n_in;
assign dout_out = mem[addr_in];
// Sampled late so a rise in the same step as a supply fall is not a pulse
always @(posedge strobe_in) #1 armed = vpp_in && gate_n_in;
always @(negedge strobe_in) begin
   if (armed && vpp_in && gate_n_in)
      mem[addr_in] = mem[addr_in] & din_in;
   armed = 1'b0;
end
endmodule

// >>> tb_uvepc_host.sv
`timescale 1ns/1ps
module tb_uvepc_host;
reg         core_clk_in = 0, rst_in = 1, rd_req_in = 0, wr_req_in = 0;
reg  [10:0] addr_in = 0;
reg  [7:0]  wdata_in = 0, bus_last = 0;
reg  [0:0]  dev_sel_in = 1'b1;
wire        busy_out, done_out, verify_err_out, mem_data_oe_out, drv;
wire        output_gate_n_out, prog_supply_high_out;
wire [7:0]  rdata_out, mem_data_out, dout, mem_data_in;
wire [10:0] mem_addr_out;
wire [0:0]  select_or_program_strobe_out;
integer     error_cnt = 0, tests_run = 0, cyc = 0, i, n;
reg  [28:0] rows [0:6];
always #12.5 core_clk_in = ~core_clk_in;
// A released line shows the inverse of its last level
assign mem_data_in = mem_data_oe_out ? mem_data_out : drv ? dout : ~bus_last;
always @(posedge core_clk_in) bus_last <= mem_data_in;
uvepc_host #(.PULSE_CYC(20), .DEV_N(1)) dut (.*);
uvepc_dev_model dev (.strobe_in(select_or_program_strobe_out[0]),
   .gate_n_in(output_gate_n_out), .vpp_in(prog_supply_high_out),
   .addr_in(mem_addr_out), .din_in(mem_data_in), .dout_out(dout),
   .drive_out(drv));
task chk(input [63:0] what, input [7:0] seen, input [7:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
   end
endtask
task start(input w, input [10:0] a, input [7:0] d);
   begin
      while (busy_out !== 1'b0) @(negedge core_clk_in);
      wr_req_in = w;
      rd_req_in = !w;
      addr_in = a;
      wdata_in = d;
      @(negedge core_clk_in);
      wr_req_in = 0;
      rd_req_in = 0;
   end
endtask
task finish_op(input [7:0] exp);
   begin
      n = 0;
      while (done_out !== 1'b1 && n < 400) begin
         @(negedge core_clk_in);
         n = n + 1;
      end
      chk("done", {7'h00, done_out}, 8'h01);
      chk("rdata", rdata_out, exp);
   end
endtask
task finish_test;
   begin
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
endtask
always @(posedge core_clk_in) begin
   cyc = cyc + 1;
   if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      finish_test;
   end
end
initial begin
   // write, address, byte, expected readback, expected verify error
   rows[0] = {1'b0, 11'h000, 8'h00, 8'hff, 1'b0};
   rows[1] = {1'b1, 11'h000, 8'h5a, 8'h5a, 1'b0};
   rows[2] = {1'b1, 11'h000, 8'h0f, 8'h0a, 1'b1};
   rows[3] = {1'b0, 11'h000, 8'h00, 8'h0a, 1'b0};
   rows[4] = {1'b1, 11'h7ff, 8'h3c, 8'h3c, 1'b0};
   rows[5] = {1'b0, 11'h7ff, 8'h00, 8'h3c, 1'b0};
   rows[6] = {1'b0, 11'h001, 8'h00, 8'hff, 1'b0};
   repeat (2) @(negedge core_clk_in);
   rst_in = 0;
   chk("rst", {busy_out, prog_supply_high_out, output_gate_n_out,
      select_or_program_strobe_out, mem_data_oe_out, done_out,
      verify_err_out}, 8'h18);
   for (i = 0; i < 7; i = i + 1) begin
      start(rows[i][28], rows[i][27:17], rows[i][16:9]);
      finish_op(rows[i][8:1]);
      if (rows[i][28])
         chk("err", verify_err_out, rows[i][0]);
   end
   start(1'b0, 11'h001, 8'h00);
   repeat (4) @(negedge core_clk_in);
   wr_req_in = 1;
   @(negedge core_clk_in);
   wr_req_in = 0;
   finish_op(8'hff);
   start(1'b0, 11'h001, 8'h00);
   finish_op(8'hff);
   start(1'b1, 11'h002, 8'h00);
   repeat (90) @(negedge core_clk_in);
   rst_in = 1;
   @(negedge core_clk_in);
   rst_in = 0;
   chk("rst", {busy_out, prog_supply_high_out, output_gate_n_out,
      select_or_program_strobe_out, mem_data_oe_out, done_out,
      verify_err_out}, 8'h18);
   start(1'b0, 11'h002, 8'h00);
   finish_op(8'hff);
   finish_test;
end
endmodule
